/* pfm_pkg.sv */
// Package with register map, field layout and select codes of the pin function mux
package pfm_pkg;

  localparam int unsigned PFM_REF_CLK_HZ = 10_000_000;
  localparam int unsigned PFM_IRQ_PULSE_MS = 2;
  localparam int unsigned PFM_IRQ_PULSE_CYC = PFM_REF_CLK_HZ / 1000 * PFM_IRQ_PULSE_MS;

  localparam logic [7:0] PFM_ADDR_SDOUT = 8'h35;
  localparam logic [7:0] PFM_ADDR_SDIN = 8'h36;
  localparam logic [7:0] PFM_ADDR_MISO = 8'h37;
  localparam logic [7:0] PFM_ADDR_SCLK = 8'h38;

  localparam logic [7:0] PFM_RST_SDOUT = 8'h12;
  localparam logic [7:0] PFM_RST_SDIN = 8'h02;
  localparam logic [7:0] PFM_RST_MISO = 8'h02;
  localparam logic [7:0] PFM_RST_SCLK = 8'h02;

  // Writable bits per register; reserved bits and read-only pin levels read from elsewhere
  localparam logic [7:0] PFM_WMASK_SDOUT = 8'h1f;
  localparam logic [7:0] PFM_WMASK_SDIN = 8'h06;
  localparam logic [7:0] PFM_WMASK_MISO = 8'h1f;
  localparam logic [7:0] PFM_WMASK_SCLK = 8'h06;

  localparam int unsigned PFM_BIT_GPO = 0;
  localparam int unsigned PFM_BIT_PIN = 0;
  localparam int unsigned PFM_BIT_KEEPER_OFF = 4;
  localparam int unsigned PFM_SEL_LSB = 1;
  localparam int unsigned PFM_SDOUT_SEL_MSB = 3;
  localparam int unsigned PFM_MISO_SEL_MSB = 4;
  localparam int unsigned PFM_IN_SEL_MSB = 2;

  localparam logic [3:0] PFM_OUT_OFF = 4'h0;
  localparam logic [3:0] PFM_OUT_PRIMARY = 4'h1;
  localparam logic [3:0] PFM_OUT_GPO = 4'h2;
  localparam logic [3:0] PFM_OUT_CLOCK_OUTPUT = 4'h3;
  localparam logic [3:0] PFM_OUT_IRQ1 = 4'h4;
  localparam logic [3:0] PFM_OUT_IRQ2 = 4'h5;
  localparam logic [2:0] PFM_SDOUT_SEC_BCLK = 3'h6;
  localparam logic [2:0] PFM_SDOUT_SEC_WCLK = 3'h7;
  localparam logic [3:0] PFM_MISO_SEC_BCLK = 4'h9;
  localparam logic [3:0] PFM_MISO_SEC_WCLK = 4'ha;

  localparam logic [1:0] PFM_IN_OFF = 2'h0;
  localparam logic [1:0] PFM_IN_PRIMARY = 2'h1;
  localparam logic [1:0] PFM_IN_GPI = 2'h2;

  // Internal sources that may be routed onto an output pin
  typedef struct packed {
    logic primary_dout;
    logic spi_rdata;
    logic clock_output;
    logic sec_bclk;
    logic sec_wclk;
    logic sec_dout;
  } pfm_src_type;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } pfm_reg_req_type;

endpackage

/* pfm_irq_pulse.sv */
// Interrupt pin shaper: one fixed-width pulse, or a repeating train until the flags are read
`timescale 1ns/1ns
module pfm_irq_pulse import pfm_pkg::*; #(
  parameter int unsigned PULSE_CYC = PFM_IRQ_PULSE_CYC
) (
  input wire logic i_ref_clk,
  input wire logic i_arst_n,
  input wire logic i_event,
  input wire logic i_repeat,
  input wire logic i_flag_read,
  output logic o_level
);

  localparam int unsigned CW = (PULSE_CYC > 1) ? $clog2(PULSE_CYC) : 1;
  localparam logic [CW-1:0] LAST = CW'(PULSE_CYC - 1);

  typedef enum logic [1:0] {PFM_IDLE, PFM_HIGH, PFM_GAP} pfm_pulse_state_type;

  pfm_pulse_state_type state_q;
  logic [CW-1:0] cnt_q;
  logic train_q;
  logic done;

  assign done = (cnt_q == LAST);

  // Only an event from idle arms the train, and it beats a flag read in the same cycle;
  // events during an active pulse or gap leave the mode alone
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      train_q <= 1'b0;
    end else if (i_event && (state_q == PFM_IDLE)) begin
      train_q <= i_repeat;
    end else if (i_flag_read) begin
      train_q <= 1'b0;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state_q <= PFM_IDLE;
      cnt_q <= '0;
    end else begin
      case (state_q)
        PFM_IDLE: begin
          cnt_q <= '0;
          if (i_event) begin
            state_q <= PFM_HIGH;
          end
        end
        PFM_HIGH: begin
          cnt_q <= done ? '0 : cnt_q + CW'(1);
          if (done) begin
            state_q <= (train_q && !i_flag_read) ? PFM_GAP : PFM_IDLE;
          end
        end
        PFM_GAP: begin
          cnt_q <= done ? '0 : cnt_q + CW'(1);
          if (!train_q || i_flag_read) begin
            state_q <= PFM_IDLE;
          end else if (done) begin
            state_q <= PFM_HIGH;
          end
        end
        default: begin
          state_q <= PFM_IDLE;
          cnt_q <= '0;
        end
      endcase
    end
  end

  // Active high while in the pulse phase; the last gap cycle raises it so the gap and
  // the pulse both last exactly the pulse count
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_level <= 1'b0;
    end else begin
      o_level <= ((state_q == PFM_IDLE) && i_event) || ((state_q == PFM_HIGH) && !done)
                 || ((state_q == PFM_GAP) && done && train_q && !i_flag_read);
    end
  end

endmodule // pfm_irq_pulse

/* pfm_pin_mux.sv */
// Function multiplexer and function registers for four multi-purpose pins
`timescale 1ns/1ns
// Functional notes
// - Serial-out keeper bit D4: 0 enables the bus keeper, 1 disables; resets to 1.
// - Serial-out select D3-D1 routes off/primary/GPO/clock/irq1/irq2/sec bclk/sec wclk.
// - Serial-out as general-purpose output drives stored bit D0, reset 0.
// - Serial-in select D2-D1: off, primary data or clock input, GP input.
// - Serial-in register bit D0 reads back the current input pin level.
// - MISO select D4-D1: off, SPI read data (SPI mode only, else off), GPO, clock, irq1, irq2.
// - MISO codes 1001 and 1010 give secondary bit and word clocks.
// - MISO as general-purpose output drives stored bit D0, reset 0.
// - SCLK select D2-D1: off, SPI clock or secondary input, GP input.
// - SCLK register bit D0 reads back the live SCLK pin level.
// - Routed interrupts are active-high 2 ms pulses, or trains until flags read.
module pfm_pin_mux import pfm_pkg::*; #(
  parameter int unsigned IRQ_PULSE_CYC = PFM_IRQ_PULSE_CYC,
  parameter logic [3:0] MISO_SEC_DOUT_CODE = 4'h8
) (
  input wire logic i_ref_clk,
  input wire logic i_arst_n,
  input wire pfm_reg_req_type i_reg_req,
  output logic [7:0] o_reg_rdata,
  input wire pfm_src_type i_src,
  input wire logic i_spi_mode,
  input wire logic i_irq1_event,
  input wire logic i_irq1_repeat,
  input wire logic i_irq2_event,
  input wire logic i_irq2_repeat,
  input wire logic i_flag_read,
  input wire logic i_sdin_pin,
  input wire logic i_sclk_pin,
  output logic o_sdout_pin,
  output logic o_sdout_oe_n,
  output logic o_sdout_keeper_en,
  output logic o_miso_pin,
  output logic o_miso_oe_n,
  output logic o_sdin_to_core,
  output logic o_sclk_to_core,
  output logic o_sclk_spi_en
);

  logic [7:0] sdout_q;
  logic [7:0] sdin_q;
  logic [7:0] miso_q;
  logic [7:0] sclk_q;
  logic [1:0] sdin_sync_q;
  logic [1:0] sclk_sync_q;
  logic [1:0] irq_lvl;
  logic [1:0] irq_evt;
  logic [1:0] irq_rpt;
  logic sdout_d;
  logic sdout_oe_n_d;
  logic miso_d;
  logic miso_oe_n_d;
  logic [2:0] sdout_sel;
  logic [3:0] miso_sel;
  logic [1:0] sdin_sel;
  logic [1:0] sclk_sel;

  function automatic logic [7:0] wr_merge(input logic [7:0] cur, input logic [7:0] wd,
                                          input logic [7:0] mask);
    wr_merge = (cur & ~mask) | (wd & mask);
  endfunction

  // Output selection common to both output pins; returns {drive, level}
  function automatic logic [1:0] out_pick(input logic [3:0] sel, input logic gpo,
                                          input logic prim, input logic [1:0] irq);
    case (sel)
      PFM_OUT_PRIMARY: out_pick = {1'b1, prim};
      PFM_OUT_GPO: out_pick = {1'b1, gpo};
      PFM_OUT_CLOCK_OUTPUT: out_pick = {1'b1, i_src.clock_output};
      PFM_OUT_IRQ1: out_pick = {1'b1, irq[0]};
      PFM_OUT_IRQ2: out_pick = {1'b1, irq[1]};
      default: out_pick = 2'b00;
    endcase
  endfunction

  assign sdout_sel = sdout_q[PFM_SDOUT_SEL_MSB:PFM_SEL_LSB];
  assign miso_sel = miso_q[PFM_MISO_SEL_MSB:PFM_SEL_LSB];
  assign sdin_sel = sdin_q[PFM_IN_SEL_MSB:PFM_SEL_LSB];
  assign sclk_sel = sclk_q[PFM_IN_SEL_MSB:PFM_SEL_LSB];

  // Function registers; reserved bits are masked so they always read zero
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      sdout_q <= PFM_RST_SDOUT;
      sdin_q <= PFM_RST_SDIN;
      miso_q <= PFM_RST_MISO;
      sclk_q <= PFM_RST_SCLK;
    end else if (i_reg_req.wr) begin
      case (i_reg_req.addr)
        PFM_ADDR_SDOUT: sdout_q <= wr_merge(sdout_q, i_reg_req.wdata, PFM_WMASK_SDOUT);
        PFM_ADDR_SDIN: sdin_q <= wr_merge(sdin_q, i_reg_req.wdata, PFM_WMASK_SDIN);
        PFM_ADDR_MISO: miso_q <= wr_merge(miso_q, i_reg_req.wdata, PFM_WMASK_MISO);
        PFM_ADDR_SCLK: sclk_q <= wr_merge(sclk_q, i_reg_req.wdata, PFM_WMASK_SCLK);
        default: sdout_q <= sdout_q;
      endcase
    end
  end

  // Pin levels come from another domain, so two flops before any use
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      sdin_sync_q <= 2'b00;
      sclk_sync_q <= 2'b00;
    end else begin
      sdin_sync_q <= {sdin_sync_q[0], i_sdin_pin};
      sclk_sync_q <= {sclk_sync_q[0], i_sclk_pin};
    end
  end

  // Read data; the pin-level bit reflects the synchronised pin
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_reg_rdata <= 8'h00;
    end else if (i_reg_req.rd) begin
      case (i_reg_req.addr)
        PFM_ADDR_SDOUT: o_reg_rdata <= sdout_q;
        PFM_ADDR_SDIN: o_reg_rdata <= {sdin_q[7:1], sdin_sync_q[1]};
        PFM_ADDR_MISO: o_reg_rdata <= miso_q;
        PFM_ADDR_SCLK: o_reg_rdata <= {sclk_q[7:1], sclk_sync_q[1]};
        default: o_reg_rdata <= 8'h00;
      endcase
    end
  end

  assign irq_evt = {i_irq2_event, i_irq1_event};
  assign irq_rpt = {i_irq2_repeat, i_irq1_repeat};

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_irq
      pfm_irq_pulse #(
        .PULSE_CYC(IRQ_PULSE_CYC)
      ) u_pulse (
        .i_ref_clk(i_ref_clk),
        .i_arst_n(i_arst_n),
        .i_event(irq_evt[g]),
        .i_repeat(irq_rpt[g]),
        .i_flag_read(i_flag_read),
        .o_level(irq_lvl[g])
      );
    end
  endgenerate

  always_comb begin
    {sdout_oe_n_d, sdout_d} = {1'b1, 1'b0};
    case (sdout_sel)
      PFM_SDOUT_SEC_BCLK: {sdout_oe_n_d, sdout_d} = {1'b0, i_src.sec_bclk};
      PFM_SDOUT_SEC_WCLK: {sdout_oe_n_d, sdout_d} = {1'b0, i_src.sec_wclk};
      default: begin
        {sdout_oe_n_d, sdout_d} = out_pick({1'b0, sdout_sel}, sdout_q[PFM_BIT_GPO],
                                           i_src.primary_dout, irq_lvl) ^ 2'b10;
      end
    endcase
  end

  always_comb begin
    {miso_oe_n_d, miso_d} = {1'b1, 1'b0};
    if (miso_sel == PFM_MISO_SEC_BCLK) begin
      {miso_oe_n_d, miso_d} = {1'b0, i_src.sec_bclk};
    end else if (miso_sel == PFM_MISO_SEC_WCLK) begin
      {miso_oe_n_d, miso_d} = {1'b0, i_src.sec_wclk};
    end else if (miso_sel == MISO_SEC_DOUT_CODE) begin
      {miso_oe_n_d, miso_d} = {1'b0, i_src.sec_dout};
    end else if (miso_sel == PFM_OUT_PRIMARY && !i_spi_mode) begin
      {miso_oe_n_d, miso_d} = {1'b1, 1'b0};
    end else begin
      {miso_oe_n_d, miso_d} = out_pick(miso_sel, miso_q[PFM_BIT_GPO], i_src.spi_rdata,
                                       irq_lvl) ^ 2'b10;
    end
  end

  // Every pin output is retimed, so a select change lands cleanly one cycle later
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_sdout_pin <= 1'b0;
      o_sdout_oe_n <= 1'b1;
      o_miso_pin <= 1'b0;
      o_miso_oe_n <= 1'b1;
      o_sdout_keeper_en <= 1'b0;
    end else begin
      o_sdout_pin <= sdout_d;
      o_sdout_oe_n <= sdout_oe_n_d;
      o_miso_pin <= miso_d;
      o_miso_oe_n <= miso_oe_n_d;
      o_sdout_keeper_en <= !sdout_q[PFM_BIT_KEEPER_OFF];
    end
  end

  // Input pins feed the core only in their primary function (select 1); off and GP input read as 0
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_sdin_to_core <= 1'b0;
      o_sclk_to_core <= 1'b0;
      o_sclk_spi_en <= 1'b0;
    end else begin
      o_sdin_to_core <= (sdin_sel == PFM_IN_PRIMARY) && sdin_sync_q[1];
      o_sclk_to_core <= (sclk_sel == PFM_IN_PRIMARY) && sclk_sync_q[1];
      o_sclk_spi_en <= (sclk_sel == PFM_IN_PRIMARY) && i_spi_mode;
    end
  end

endmodule // pfm_pin_mux

/* pfm_pin_mux_checker.sv */
// Port assertions for the pin function mux
`timescale 1ns/1ns
module pfm_pin_mux_checker import pfm_pkg::*; #(
  parameter int unsigned IRQ_PULSE_CYC = 4,
  parameter logic [3:0] MISO_SEC_DOUT_CODE = 4'h8
) (
  input wire logic i_ref_clk,
  input wire logic i_arst_n,
  input wire pfm_reg_req_type i_reg_req,
  input wire logic i_spi_mode,
  input wire logic o_sdout_pin,
  input wire logic o_sdout_oe_n,
  input wire logic o_sdout_keeper_en,
  input wire logic o_miso_pin,
  input wire logic o_miso_oe_n,
  input wire logic o_sdin_to_core,
  input wire logic o_sclk_spi_en
);
  logic [7:0] wd;
  logic [2:0] sel_q;
  logic w35, w36, w37, w38;
  assign wd = i_reg_req.wdata;
  assign w35 = i_reg_req.wr && i_reg_req.addr == PFM_ADDR_SDOUT;
  assign w36 = i_reg_req.wr && i_reg_req.addr == PFM_ADDR_SDIN;
  assign w37 = i_reg_req.wr && i_reg_req.addr == PFM_ADDR_MISO;
  assign w38 = i_reg_req.wr && i_reg_req.addr == PFM_ADDR_SCLK;
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) sel_q <= 3'h1;
    else if (w35) sel_q <= wd[3:1];
  end
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_arst_n);
  property p_keep; w35 ##1 !w35 |=> o_sdout_keeper_en == !$past(wd[4], 2); endproperty
  a_keep: assert property (p_keep) else $error("keeper");
  property p_gpo; w35 && wd[3:1] == 3'h2 ##1 !w35 |=> !o_sdout_oe_n && o_sdout_pin == $past(wd[0], 2); endproperty
  a_gpo: assert property (p_gpo) else $error("sdout gpo");
  property p_off; w35 && wd[3:1] == 3'h0 ##1 !w35 |=> o_sdout_oe_n && !o_sdout_pin; endproperty
  a_off: assert property (p_off) else $error("sdout off");
  property p_mgpo; w37 && wd[4:1] == 4'h2 ##1 !w37 |=> !o_miso_oe_n && o_miso_pin == $past(wd[0], 2); endproperty
  a_mgpo: assert property (p_mgpo) else $error("miso gpo");
  property p_mi2c; w37 && wd[4:1] == 4'h1 ##1 (!w37 && !i_spi_mode) |=> o_miso_oe_n; endproperty
  a_mi2c: assert property (p_mi2c) else $error("miso i2c");
  property p_spien; w38 && wd[2:1] == 2'h1 ##1 (!w38 && i_spi_mode) |=> o_sclk_spi_en; endproperty
  a_spien: assert property (p_spien) else $error("spi clock");
  property p_sdoff; w36 && wd[2:1] == 2'h0 ##1 !w36 [*3] |-> !o_sdin_to_core; endproperty
  a_sdoff: assert property (p_sdoff) else $error("serial in off");
  // Pulse of 4 matches the shortened pulse parameter; a select change excuses it
  property p_irq;
    $rose(o_sdout_pin) && sel_q == 3'h4 && $past(sel_q) == 3'h4 && $past(sel_q, 2) == 3'h4
      |-> (o_sdout_pin [*4] ##1 !o_sdout_pin) or (##[0:4] sel_q != 3'h4);
  endproperty
  a_irq: assert property (p_irq) else $error("irq pulse");
  c_gpo: cover property (w35 && wd[3:1] == 3'h2);
  c_irq: cover property ($rose(o_sdout_pin) && sel_q == 3'h4);
  c_mi2c: cover property (w37 && wd[4:1] == 4'h1 && !i_spi_mode);
endmodule // pfm_pin_mux_checker
bind pfm_pin_mux pfm_pin_mux_checker #(.IRQ_PULSE_CYC(IRQ_PULSE_CYC),
  .MISO_SEC_DOUT_CODE(MISO_SEC_DOUT_CODE)) u_chk (.i_ref_clk(i_ref_clk),
  .i_arst_n(i_arst_n), .i_reg_req(i_reg_req), .i_spi_mode(i_spi_mode),
  .o_sdout_pin(o_sdout_pin), .o_sdout_oe_n(o_sdout_oe_n),
  .o_sdout_keeper_en(o_sdout_keeper_en), .o_miso_pin(o_miso_pin),
  .o_miso_oe_n(o_miso_oe_n), .o_sdin_to_core(o_sdin_to_core),
  .o_sclk_spi_en(o_sclk_spi_en));

/* pfm_far_side.sv */
// Far side: audio source levels and externally driven pin levels
`timescale 1ns/1ns
module pfm_far_side import pfm_pkg::*; (
  input wire logic i_ref_clk,
  input wire logic [31:0] i_rnd,
  output pfm_src_type o_src,
  output logic o_sdin_pin,
  output logic o_sclk_pin
);
  initial begin
    o_src = '0;
    o_sdin_pin = 1'b0;
    o_sclk_pin = 1'b0;
  end
  // Sources take new random levels each cycle; pins move rarely so the synchronised readback settles
  always @(posedge i_ref_clk) begin
    o_src <= #2 i_rnd[31:26];
    if (i_rnd[11:9] == 3'h0) o_sdin_pin <= #2 i_rnd[12];
    if (i_rnd[14:12] == 3'h0) o_sclk_pin <= #2 i_rnd[15];
  end
endmodule // pfm_far_side

/* tb_pfm_pin_mux.sv */
// Self-checking bench for the pin function mux against a reference model
`timescale 1ns/1ns
module tb_pfm_pin_mux import pfm_pkg::*;;
  localparam int PC = 4;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  pfm_reg_req_type req = '0;
  pfm_src_type src;
  logic spi = 1'b1, e1 = 1'b0, e2 = 1'b0, fr = 1'b0, r1 = 1'b0, r2 = 1'b0, sdin, sclk;
  logic [7:0] rdata;
  logic sd_p, sd_oe, kp, mi_p, mi_oe, sdin_c, sclk_c, spi_en;
  logic [31:0] rnd = 32'h000159c1;
  logic [7:0] rg [4];
  logic [3:0] hin = '0, hsc = '0;
  int err_total = 0, checked = 0, cyc = 0, c1 = 0, c2 = 0;
  int g1 = 0, g2 = 0, t1 = 0, t2 = 0;
  pfm_far_side far (.i_ref_clk(clk), .i_rnd(rnd), .o_src(src), .o_sdin_pin(sdin),
    .o_sclk_pin(sclk));
  pfm_pin_mux #(.IRQ_PULSE_CYC(PC)) dut (.i_ref_clk(clk), .i_arst_n(rst_n),
    .i_reg_req(req), .o_reg_rdata(rdata), .i_src(src), .i_spi_mode(spi),
    .i_irq1_event(e1), .i_irq1_repeat(r1), .i_irq2_event(e2), .i_irq2_repeat(r2),
    .i_flag_read(fr), .i_sdin_pin(sdin), .i_sclk_pin(sclk), .o_sdout_pin(sd_p),
    .o_sdout_oe_n(sd_oe), .o_sdout_keeper_en(kp), .o_miso_pin(mi_p), .o_miso_oe_n(mi_oe),
    .o_sdin_to_core(sdin_c), .o_sclk_to_core(sclk_c), .o_sclk_spi_en(spi_en));
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return x[0] ? (x >> 1) ^ 32'h80200003 : x >> 1;
  endfunction
  // Expected {oe_n, level} of an output pin
  function automatic logic [1:0] route(input logic [3:0] s, input logic g, input logic mi);
    logic [1:0] r;
    r = 2'b10;
    case (s)
      4'h1: if (!mi || spi) r = {1'b0, mi ? src.spi_rdata : src.primary_dout};
      4'h2: r = {1'b0, g};
      4'h3: r = {1'b0, src.clock_output};
      4'h4: r = {1'b0, c1 > 0};
      4'h5: r = {1'b0, c2 > 0};
      4'h6, 4'h7: if (!mi) r = {1'b0, s[0] ? src.sec_wclk : src.sec_bclk};
      4'h8: if (mi) r = {1'b0, src.sec_dout};
      4'h9: if (mi) r = {1'b0, src.sec_bclk};
      4'ha: if (mi) r = {1'b0, src.sec_wclk};
      default: r = 2'b10;
    endcase
    return r;
  endfunction
  function automatic logic [7:0] rdx(input logic [7:0] a);
    case (a)
      8'h35: return rg[0];
      8'h36: return rg[1] | {7'h0, hin[0]};
      8'h37: return rg[2];
      8'h38: return rg[3] | {7'h0, hsc[0]};
      default: return 8'h00;
    endcase
  endfunction
  task automatic cmp_pin(input string n, input logic [1:0] e, input logic [1:0] s);
    checked++;
    if (s !== e) begin
      err_total++;
      $display("[ERR] %s expected %b seen %b", n, e, s);
    end
  endtask
  task automatic cmp_rd(input logic [7:0] e, input logic [7:0] m, input logic [7:0] s);
    checked++;
    if ((s & m) !== (e & m)) begin
      err_total++;
      $display("[ERR] rdata expected %h seen %h", e, s);
    end
  endtask
  // Interrupt model: h counts the high phase, g the gap of a train, t the train mode
  task automatic irq_model(inout int h, inout int g, inout int t, input logic e,
                           input logic r);
    if (h > 0) begin
      h--;
      if (fr) t = 0;
      if (h == 0 && t != 0) g = PC;
    end else if (g > 0) begin
      g--;
      if (fr) t = 0;
      if (t == 0) g = 0;
      else if (g == 0) h = PC;
    end else if (e) begin
      h = PC;
      t = r;
    end else if (fr) begin
      t = 0;
    end
  endtask
  task automatic close_out();
    if (err_total == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic step();
    logic si, ss;
    hin = {hin[2:0], sdin};
    hsc = {hsc[2:0], sclk};
    si = &hin || ~|hin;
    ss = &hsc || ~|hsc;
    cmp_pin("sdout", route({1'b0, rg[0][3:1]}, rg[0][0], 1'b0), {sd_oe, sd_p});
    cmp_pin("miso", route(rg[2][4:1], rg[2][0], 1'b1), {mi_oe, mi_p});
    cmp_pin("keeper", {1'b0, ~rg[0][4]}, {1'b0, kp});
    cmp_pin("spi_en", {1'b0, rg[3][2:1] == 2'h1 && spi}, {1'b0, spi_en});
    if (si) cmp_pin("sdin_c", {1'b0, rg[1][2:1] == 2'h1 && hin[0]}, {1'b0, sdin_c});
    if (ss) cmp_pin("sclk_c", {1'b0, rg[3][2:1] == 2'h1 && hsc[0]}, {1'b0, sclk_c});
    if (req.rd) cmp_rd(rdx(req.addr), {7'h7f, !(req.addr == 8'h36 && !si) && !(req.addr == 8'h38 && !ss)}, rdata);
    if (req.wr && req.addr inside {[8'h35:8'h38]}) rg[2'(req.addr - 8'h35)] = req.wdata;
    irq_model(c1, g1, t1, e1, r1);
    irq_model(c2, g2, t2, e2, r2);
  endtask
  task automatic drive(input int i);
    logic [7:0] a, d;
    rnd = lfsr(rnd);
    a = 8'h34 + 8'(rnd[2:0] % 3'h6);
    d = rnd[15:8];
    if (a == 8'h37 && (d[4:1] > 4'ha || d[4:2] == 3'h3)) d[4:1] = 4'h9;
    if (a inside {8'h36, 8'h38} && d[2:1] == 2'h3) d[2] = 1'b0;
    req.wr = rnd[4:3] == 2'h0 && i >= 4;
    req.rd = rnd[4:3] == 2'h1 || i < 4;
    req.addr = i < 4 ? 8'h35 + 8'(i) : a;
    req.wdata = d & (a inside {8'h35, 8'h37} ? 8'h1f : 8'h06);
    e1 = rnd[20:17] == 4'h0;
    e2 = rnd[24:21] == 4'h0;
    fr = rnd[27:25] == 3'h0;
    r1 = rnd[5];
    r2 = rnd[6];
    if (rnd[31:28] == 4'h0) spi = ~spi;
  endtask
  initial begin
    forever #50 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc > 6000) begin
      err_total++;
      close_out();
    end
  end
  initial begin
    rg[0] = 8'h12;
    rg[1] = 8'h02;
    rg[2] = 8'h02;
    rg[3] = 8'h02;
    repeat (8) @(posedge clk);
    #2 rst_n = 1'b1;
    for (int i = 0; i < 3000; i++) begin
      @(posedge clk);
      #1 step();
      #1 drive(i);
    end
    close_out();
  end
endmodule // tb_pfm_pin_mux
